// >>> logic/cat_core.v
// charge accounting, empty thresholds, reset detection and temperature step
`timescale 1ns/1ps
`include "cat_consts.vh"
module cat_core #(
  parameter RESUME_CYC = `CAT_RESUME_CYC,
  parameter CNT_W      = 16
) (
  // clock and reset
  input  wire             CLK,
  input  wire             SYS_RST,
  // analog comparator results, asynchronous
  input  wire             CMP_BELOW_FINAL,
  input  wire             CMP_BELOW_FIRST,
  input  wire             CMP_ABOVE_MAX,
  input  wire             CMP_ABOVE_PRESENT,
  input  wire             CMP_ABOVE_RESTART,
  input  wire             CMP_SENSE_SUPPRESS,
  // serial register-reset command, same clock
  input  wire             REG_RESET_CMD,
  // compensated count pulses, same clock
  input  wire             CHG_TICK,
  input  wire             DSG_TICK,
  input  wire             SELF_DSG_TICK,
  input  wire             CHG_ACTIVE,
  // programming pins, 2-bit level codes, sampled on the first clock after reset
  input  wire [1:0]       PROG1,
  input  wire [1:0]       PROG2,
  input  wire [1:0]       PROG3,
  input  wire [1:0]       PROG4,
  input  wire             DISPLAY_ABSOLUTE,
  // temperature from sensor, signed whole degrees
  input  wire signed [7:0] TEMP_DEG,
  // status and results
  output reg              EMPTY_OE,
  output reg              FINAL_EMPTY_FLAG,
  output reg              FIRST_LOW_FLAG,
  output reg              BATTERY_PRESENT,
  output reg              DEVICE_RESET,
  output reg  [7:0]       TEMPERATURE_STEP,
  output reg  [CNT_W-1:0] AVAILABLE_CHARGE,
  output reg  [CNT_W-1:0] DISCHARGE_COUNT,
  output reg  [CNT_W-1:0] LEARNED_CAPACITY,
  output reg  [CNT_W-1:0] PROGRAMMED_FULL,
  output reg  [2:0]       RATE_SCALE,
  output reg  [CNT_W-1:0] FULL_REFERENCE,
  output reg              VALID_CHARGE
);
  // synchronized comparator levels
  wire below_final;
  wire below_first;
  wire above_max;
  wire above_present;
  wire above_restart;
  wire sense_suppress;

  cat_sync u_s0 (.CLK(CLK), .SYS_RST(SYS_RST), .d_in(CMP_BELOW_FINAL),    .q_out(below_final));
  cat_sync u_s1 (.CLK(CLK), .SYS_RST(SYS_RST), .d_in(CMP_BELOW_FIRST),    .q_out(below_first));
  cat_sync u_s2 (.CLK(CLK), .SYS_RST(SYS_RST), .d_in(CMP_ABOVE_MAX),      .q_out(above_max));
  cat_sync u_s3 (.CLK(CLK), .SYS_RST(SYS_RST), .d_in(CMP_ABOVE_PRESENT),  .q_out(above_present));
  cat_sync u_s4 (.CLK(CLK), .SYS_RST(SYS_RST), .d_in(CMP_ABOVE_RESTART),  .q_out(above_restart));
  cat_sync u_s5 (.CLK(CLK), .SYS_RST(SYS_RST), .d_in(CMP_SENSE_SUPPRESS), .q_out(sense_suppress));

  // previous samples for crossing detection
  reg        above_max_q;
  reg        above_restart_q;
  reg        prev_valid_q;
  reg [31:0] resume_cnt_q;
  reg        mon_en_q;
  reg [CNT_W-1:0] chg_run_q;
  reg        learned_q;
  reg        qual_q;
  reg        init_q;

  wire rise_restart = prev_valid_q & above_restart & ~above_restart_q;
  wire fall_max     = prev_valid_q & above_max_q & ~above_max;
  wire dev_rst      = rise_restart | fall_max | REG_RESET_CMD;

  always @(posedge CLK) begin
    if (SYS_RST) begin
      above_max_q     <= 1'b0;
      above_restart_q <= 1'b0;
      prev_valid_q    <= 1'b0;
      DEVICE_RESET    <= 1'b0;
      BATTERY_PRESENT <= 1'b0;
    end else begin
      above_max_q     <= above_max;
      above_restart_q <= above_restart;
      prev_valid_q    <= 1'b1;
      DEVICE_RESET    <= dev_rst;
      BATTERY_PRESENT <= above_present;
    end
  end

  // end-of-discharge monitor gate with half-second resume
  always @(posedge CLK) begin
    if (SYS_RST) begin
      resume_cnt_q <= 32'h0;
      mon_en_q     <= 1'b1;
    end else if (sense_suppress) begin
      resume_cnt_q <= 32'h0;
      mon_en_q     <= 1'b0;
    end else if (!mon_en_q) begin
      if (resume_cnt_q >= RESUME_CYC - 1)
        mon_en_q <= 1'b1;
      else
        resume_cnt_q <= resume_cnt_q + 32'h1;
    end
  end

  // valid charge detection: sustained activity over 256 counts
  always @(posedge CLK) begin
    if (SYS_RST || dev_rst) begin
      chg_run_q    <= {CNT_W{1'b0}};
      VALID_CHARGE <= 1'b0;
    end else if (!CHG_ACTIVE) begin
      chg_run_q    <= {CNT_W{1'b0}};
      VALID_CHARGE <= 1'b0;
    end else if (CHG_TICK && !VALID_CHARGE) begin
      chg_run_q <= chg_run_q + {{(CNT_W-1){1'b0}}, 1'b1};
      if (chg_run_q >= `CAT_VALID_CHG_CNT)
        VALID_CHARGE <= 1'b1;
    end
  end

  wire valid_start = CHG_TICK & CHG_ACTIVE & ~VALID_CHARGE &
                     (chg_run_q >= `CAT_VALID_CHG_CNT);

  // latched empty flags; set wins over clear in the same cycle
  always @(posedge CLK) begin
    if (SYS_RST || dev_rst) begin
      FINAL_EMPTY_FLAG <= 1'b0;
      FIRST_LOW_FLAG   <= 1'b0;
      EMPTY_OE         <= 1'b1;
    end else begin
      if (mon_en_q && below_final) begin
        FINAL_EMPTY_FLAG <= 1'b1;
        EMPTY_OE         <= 1'b0;
      end else if (valid_start) begin
        FINAL_EMPTY_FLAG <= 1'b0;
        EMPTY_OE         <= 1'b1;
      end
      if (mon_en_q && below_first)
        FIRST_LOW_FLAG <= 1'b1;
      else if (valid_start)
        FIRST_LOW_FLAG <= 1'b0;
    end
  end

  // programmed full count and rate scale from pins
  reg [CNT_W-1:0] pfc_d;
  reg [2:0]       scale_d;
  always @* begin
    case ({PROG1, PROG2})
      {`CAT_PIN_H, `CAT_PIN_H}: pfc_d = `CAT_PFC_HH;
      {`CAT_PIN_H, `CAT_PIN_Z}: pfc_d = `CAT_PFC_HZ;
      {`CAT_PIN_H, `CAT_PIN_L}: pfc_d = `CAT_PFC_HL;
      {`CAT_PIN_Z, `CAT_PIN_H}: pfc_d = `CAT_PFC_ZH;
      {`CAT_PIN_Z, `CAT_PIN_Z}: pfc_d = `CAT_PFC_ZZ;
      {`CAT_PIN_Z, `CAT_PIN_L}: pfc_d = `CAT_PFC_ZL;
      {`CAT_PIN_L, `CAT_PIN_H}: pfc_d = `CAT_PFC_LH;
      {`CAT_PIN_L, `CAT_PIN_Z}: pfc_d = `CAT_PFC_LZ;
      default:                  pfc_d = `CAT_PFC_LL;
    endcase
    // scale index 0..5 means 1/80 .. 1/2560
    case (PROG3)
      `CAT_PIN_H: scale_d = 3'h0;
      `CAT_PIN_Z: scale_d = 3'h1;
      default:    scale_d = 3'h2;
    endcase
    if (PROG4 == `CAT_PIN_Z)
      scale_d = scale_d + 3'h3;
  end

  // counters; pins are caught on the first clock after reset
  wire at_cap   = (AVAILABLE_CHARGE == LEARNED_CAPACITY);
  // a learned value may sit below the present count, so equality alone never stops it
  wire at_limit = learned_q ? (AVAILABLE_CHARGE >= LEARNED_CAPACITY) :
                              (AVAILABLE_CHARGE >= PROGRAMMED_FULL);
  wire dec_tick = DSG_TICK | SELF_DSG_TICK;  // compensation done upstream
  wire dcr_inc  = ~FIRST_LOW_FLAG & (DSG_TICK | (SELF_DSG_TICK & |AVAILABLE_CHARGE));

  always @(posedge CLK) begin
    if (SYS_RST || dev_rst) begin
      init_q           <= 1'b1;
      learned_q        <= 1'b0;
      qual_q           <= 1'b0;
      AVAILABLE_CHARGE <= {CNT_W{1'b0}};
      DISCHARGE_COUNT  <= {CNT_W{1'b0}};
      LEARNED_CAPACITY <= {CNT_W{1'b0}};
      PROGRAMMED_FULL  <= {CNT_W{1'b0}};
      RATE_SCALE       <= 3'h0;
    end else if (init_q) begin
      init_q           <= 1'b0;
      PROGRAMMED_FULL  <= pfc_d;
      RATE_SCALE       <= scale_d;
      LEARNED_CAPACITY <= pfc_d;
    end else begin
      if (CHG_TICK && !at_cap && !at_limit)
        AVAILABLE_CHARGE <= AVAILABLE_CHARGE + {{(CNT_W-1){1'b0}}, 1'b1};
      else if (dec_tick && |AVAILABLE_CHARGE)
        AVAILABLE_CHARGE <= AVAILABLE_CHARGE - {{(CNT_W-1){1'b0}}, 1'b1};
      if (at_cap) begin
        DISCHARGE_COUNT <= {CNT_W{1'b0}};
        qual_q          <= 1'b1;   // full reached, discharge may qualify
      end else if (dcr_inc && DISCHARGE_COUNT != `CAT_CNT_MAX)
        DISCHARGE_COUNT <= DISCHARGE_COUNT + {{(CNT_W-1){1'b0}}, 1'b1};
      if (valid_start && !FIRST_LOW_FLAG)
        qual_q <= 1'b0;            // partial charge disqualifies
      if (valid_start && FIRST_LOW_FLAG && qual_q) begin
        LEARNED_CAPACITY <= DISCHARGE_COUNT;
        learned_q        <= 1'b1;
        qual_q           <= 1'b0;
      end
    end
  end

  // display full reference
  always @(posedge CLK) begin
    if (SYS_RST)
      FULL_REFERENCE <= {CNT_W{1'b0}};
    else if (DISPLAY_ABSOLUTE)
      FULL_REFERENCE <= PROGRAMMED_FULL;
    else
      FULL_REFERENCE <= LEARNED_CAPACITY;
  end

  // temperature step: upper digit 0..C, bands of 10 degrees from -30
  reg [3:0] step_d;
  reg [7:0] band_d;
  always @* begin
    // signed math keeps the band index in 0..10 inside the used range
    band_d = (TEMP_DEG + 8'sd30) / 8'sd10;
    if (TEMP_DEG < -8'sd30)
      step_d = 4'h0;
    else if (TEMP_DEG >= 8'sd80)
      step_d = `CAT_TSTEP_MAX;
    else
      step_d = 4'h1 + band_d[3:0];
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      TEMPERATURE_STEP <= 8'h00;
    else
      TEMPERATURE_STEP <= {step_d, 4'h0};
  end
endmodule

// >>> include/cat_consts.vh
// constants for the charge accounting and threshold core
// Function
// - compare cell voltage against two fixed empty levels, final one at 0.95V.
// - below-threshold flags latch, ignoring later voltage, until next valid charge.
// - suspend empty monitoring at sense <= -250mV; resume half second after rising.
// - empty output goes high impedance below final level, latched until valid charge.
// - battery present above 0.1V; reset on rise from 0.25V or fall from 2.25V.
// - serial register-reset command also resets the device.
// - temperature quantized in 10C steps from -30C to +80C for compensation.
// - temperature step in upper hex digit: 0 below -30C, C above 80C.
// - charge/discharge get temperature and rate compensation; self-discharge temperature only.
// - charge increments available count; discharge and self-discharge decrement it, raise discharge count.
// - discharge count becomes learned capacity only after full-to-empty without partial charge.
// - learned capacity loads programmed full count on initialization.
// - learned capacity update needs qualified discharge from full to below first level.
// - before learning, available count rises only up to programmed full count.
// - relative display uses learned capacity as 100% reference.
// - absolute display uses programmed full count as 100% reference.
// - full count and rate scale derive from first four three-level pins.
// - valid charge is sustained charge beyond 256 counts; it clears empty latches.
// - available count stops incrementing once equal to learned capacity.
`ifndef CAT_CONSTS_VH
`define CAT_CONSTS_VH
`define CAT_CLK_MHZ        250
`define CAT_RESUME_MS      500
`define CAT_RESUME_CYC     (`CAT_RESUME_MS * 1000 * `CAT_CLK_MHZ)
`define CAT_VALID_CHG_CNT  16'h0100
`define CAT_CNT_MAX        16'hFFFF
`define CAT_PIN_H          2'h2
`define CAT_PIN_Z          2'h1
`define CAT_PIN_L          2'h0
`define CAT_TSTEP_MAX      4'hC
`define CAT_TEMP_LSB       4
`define CAT_PFC_HH         16'hC000
`define CAT_PFC_HZ         16'hB000
`define CAT_PFC_HL         16'hA000
`define CAT_PFC_ZH         16'h9000
`define CAT_PFC_ZZ         16'h8400
`define CAT_PFC_ZL         16'h7800
`define CAT_PFC_LH         16'h6C00
`define CAT_PFC_LZ         16'h6400
`define CAT_PFC_LL         16'h5800
`endif

// >>> logic/cat_sync.v
// three-stage input synchronizer with agreement filter
`timescale 1ns/1ps
module cat_sync (
  // clock and reset
  input  wire CLK,
  input  wire SYS_RST,
  // raw and filtered level
  input  wire d_in,
  output reg  q_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge CLK) begin
    if (SYS_RST) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      q_out <= 1'b0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change accepted only when stages two and three agree
      if (s2_q == s3_q)
        q_out <= s3_q;
    end
  end
endmodule

// >>> bench/cat_core_checker.sv
// port-level assertions for the charge accounting core
`timescale 1ns/1ps
module cat_core_checker #(
  parameter CNT_W = 16
) (
  // clock and reset
  input logic             CLK,
  input logic             SYS_RST,
  // stimulus
  input logic             CMP_BELOW_FINAL,
  input logic             REG_RESET_CMD,
  input logic             CHG_TICK,
  input logic             DSG_TICK,
  input logic             DISPLAY_ABSOLUTE,
  // results
  input logic             EMPTY_OE,
  input logic             FINAL_EMPTY_FLAG,
  input logic             DEVICE_RESET,
  input logic             VALID_CHARGE,
  input logic [7:0]       TEMPERATURE_STEP,
  input logic [CNT_W-1:0] AVAILABLE_CHARGE,
  input logic [CNT_W-1:0] LEARNED_CAPACITY,
  input logic [CNT_W-1:0] PROGRAMMED_FULL,
  input logic [CNT_W-1:0] FULL_REFERENCE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // mode held two cycles so the registered reference has caught up
  sequence abs_held;
    DISPLAY_ABSOLUTE [*2] ##0 $stable(PROGRAMMED_FULL);
  endsequence
  sequence rel_held;
    !DISPLAY_ABSOLUTE [*2] ##0 $stable(LEARNED_CAPACITY);
  endsequence
  tstep_range_a: assert property (TEMPERATURE_STEP[7:4] <= 4'hC)
    else $error("temperature step above top code");
  empty_latch_a: assert property (FINAL_EMPTY_FLAG && !DEVICE_RESET &&
    !$past(DEVICE_RESET) |=> FINAL_EMPTY_FLAG || VALID_CHARGE || DEVICE_RESET)
    else $error("empty flag dropped without valid charge");
  valid_clear_a: assert property ($rose(VALID_CHARGE) && !CMP_BELOW_FINAL &&
    $past(CMP_BELOW_FINAL, 6) == 1'b0 |-> !FINAL_EMPTY_FLAG)
    else $error("valid charge left empty flag set");
  empty_out_a: assert property ($rose(FINAL_EMPTY_FLAG) |-> ##[0:2] !EMPTY_OE)
    else $error("empty output not released");
  reg_reset_a: assert property (REG_RESET_CMD |=> DEVICE_RESET)
    else $error("reset command ignored");
  dsg_zero_a: assert property (DSG_TICK && !CHG_TICK && AVAILABLE_CHARGE == 0
    |=> AVAILABLE_CHARGE == 0)
    else $error("available charge went below zero");
  chg_limit_a: assert property (CHG_TICK && !DEVICE_RESET &&
    AVAILABLE_CHARGE == LEARNED_CAPACITY |=> AVAILABLE_CHARGE <= $past(AVAILABLE_CHARGE))
    else $error("available charge passed learned capacity");
  abs_ref_a: assert property (abs_held |-> FULL_REFERENCE == PROGRAMMED_FULL)
    else $error("absolute reference wrong");
  rel_ref_a: assert property (rel_held |-> FULL_REFERENCE == LEARNED_CAPACITY)
    else $error("relative reference wrong");
endmodule
bind cat_core cat_core_checker #(.CNT_W(CNT_W)) cat_core_checker_i (.CLK(CLK),
  .SYS_RST(SYS_RST), .CMP_BELOW_FINAL(CMP_BELOW_FINAL), .REG_RESET_CMD(REG_RESET_CMD),
  .CHG_TICK(CHG_TICK), .DSG_TICK(DSG_TICK), .DISPLAY_ABSOLUTE(DISPLAY_ABSOLUTE),
  .EMPTY_OE(EMPTY_OE), .FINAL_EMPTY_FLAG(FINAL_EMPTY_FLAG), .DEVICE_RESET(DEVICE_RESET),
  .VALID_CHARGE(VALID_CHARGE), .TEMPERATURE_STEP(TEMPERATURE_STEP),
  .AVAILABLE_CHARGE(AVAILABLE_CHARGE), .LEARNED_CAPACITY(LEARNED_CAPACITY),
  .PROGRAMMED_FULL(PROGRAMMED_FULL), .FULL_REFERENCE(FULL_REFERENCE));

// >>> bench/testbench.sv
// self-checking bench for the charge accounting core
`timescale 1ns/1ps
`include "cat_consts.vh"
module testbench;
  logic        clk = 0, rst = 1, cbf = 0, cbl = 0, cam = 0, cap = 1, car = 0, css = 0;
  logic        rrc = 0, ct = 0, dt = 0, st = 0, ca = 0, da = 0;
  logic [1:0]  p1 = 2'h1, p4 = 2'h0;
  logic [7:0]  tmp = 8'h19;
  wire         e_oe, f_fl, l_fl, bp, dr, vc;
  wire  [7:0]  ts;
  wire  [2:0]  rs;
  wire  [15:0] available_charge_counter, discharge_counter, learned_capacity, programmed_full_count, fr;
  int          fail_count = 0, num_checks = 0, k;
  always #2 clk = ~clk;
  // short resume delay keeps the suppression test brief
  cat_core #(.RESUME_CYC(100)) cat_core_i (.CLK(clk), .SYS_RST(rst), .CMP_BELOW_FINAL(cbf),
    .CMP_BELOW_FIRST(cbl), .CMP_ABOVE_MAX(cam), .CMP_ABOVE_PRESENT(cap),
    .CMP_ABOVE_RESTART(car), .CMP_SENSE_SUPPRESS(css), .REG_RESET_CMD(rrc), .CHG_TICK(ct),
    .DSG_TICK(dt), .SELF_DSG_TICK(st), .CHG_ACTIVE(ca), .PROG1(p1), .PROG2(2'h1),
    .PROG3(2'h1), .PROG4(p4), .DISPLAY_ABSOLUTE(da), .TEMP_DEG(tmp), .EMPTY_OE(e_oe),
    .FINAL_EMPTY_FLAG(f_fl), .FIRST_LOW_FLAG(l_fl), .BATTERY_PRESENT(bp), .DEVICE_RESET(dr),
    .TEMPERATURE_STEP(ts), .AVAILABLE_CHARGE(available_charge_counter), .DISCHARGE_COUNT(discharge_counter),
    .LEARNED_CAPACITY(learned_capacity), .PROGRAMMED_FULL(programmed_full_count), .RATE_SCALE(rs), .FULL_REFERENCE(fr),
    .VALID_CHARGE(vc));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #0.5;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // kind 0 charge, 1 discharge, 2 self-discharge; pulses back to back
  task automatic ticks(input int kind, input int n);
    repeat (n) begin
      {ct, dt, st} = 3'b100 >> kind;
      step(1);
    end
    {ct, dt, st} = 3'b000;
    step(1);
  endtask
  task automatic wait_reset();
    int i;
    for (i = 0; i < 12 && dr !== 1'b1; i++) step(1);
    num_checks++;
    if (dr !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t no device reset", $time);
      give_verdict();
    end
    step(3);
  endtask
  initial begin
    step(4);
    rst = 0;
    step(8);
    chk(learned_capacity, `CAT_PFC_ZZ);
    chk(programmed_full_count, `CAT_PFC_ZZ);
    chk({13'h0, rs}, 16'h0001);
    chk({15'h0, bp}, 16'h0001);
    chk({15'h0, e_oe}, 16'h0001);
    ticks(1, 1);
    ticks(2, 1);
    chk(available_charge_counter, 16'h0000);
    chk(discharge_counter, 16'h0001);
    css = 1;
    step(4);
    cbl = 1;
    step(8);
    cbl = 0;
    step(4);
    css = 0;
    step(8);
    chk({15'h0, l_fl}, 16'h0000);
    step(120);
    cbl = 1;
    cbf = 1;
    step(8);
    cbl = 0;
    cbf = 0;
    step(8);
    chk({14'h0, l_fl, f_fl}, 16'h0003);
    chk({15'h0, e_oe}, 16'h0000);
    ca = 1;
    ticks(0, 256);
    chk({14'h0, vc, f_fl}, 16'h0001);
    ticks(0, 1);
    chk({13'h0, vc, f_fl, e_oe}, 16'h0005);
    chk(available_charge_counter, 16'h0101);
    ticks(0, 33800);
    chk(available_charge_counter, `CAT_PFC_ZZ);
    ca = 0;
    ticks(1, 2);
    ticks(2, 1);
    chk(available_charge_counter, `CAT_PFC_ZZ - 16'h0003);
    // qualified discharge from full: 2 + 300 discharge counts, then first low level
    ticks(1, 300);
    cbl = 1;
    step(8);
    cbl = 0;
    step(8);
    chk({15'h0, l_fl}, 16'h0001);
    ca = 1;
    ticks(0, 257);
    chk(learned_capacity, 16'h012E);
    ticks(0, 4);
    chk(available_charge_counter, 16'h83D2);
    ca = 0;
    step(3);
    chk(fr, 16'h012E);
    da = 1;
    step(3);
    chk(fr, `CAT_PFC_ZZ);
    da = 0;
    for (k = 0; k < 13; k++) begin
      tmp = (k == 0) ? 8'hD8 : (k == 12) ? 8'h55 : 8'(-35 + 10 * k);
      step(3);
      chk({12'h0, ts[7:4]}, 16'(k));
    end
    rrc = 1;
    step(1);
    rrc = 0;
    wait_reset();
    chk(available_charge_counter, 16'h0000);
    da = 1;
    step(3);
    chk(fr, `CAT_PFC_ZZ);
    da = 0;
    step(3);
    chk(fr, `CAT_PFC_ZZ);
    p1 = 2'h2;
    p4 = 2'h1;
    car = 1;
    wait_reset();
    chk(programmed_full_count, `CAT_PFC_HZ);
    chk({13'h0, rs}, 16'h0004);
    cam = 1;
    step(8);
    cam = 0;
    wait_reset();
    give_verdict();
  end
endmodule
